/* hdl/mct_pkg.sv */
// package: register map, field layout and encodings of the counter/timer channel
package mct_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_COMMAND    = 8'h04;
    localparam logic [7:0] OFS_LOAD       = 8'h08;
    localparam logic [7:0] OFS_CMP_LOW    = 8'h0C;
    localparam logic [7:0] OFS_CMP_HIGH   = 8'h10;
    localparam logic [7:0] OFS_DIVIDER    = 8'h14;
    localparam logic [7:0] OFS_PERIODS    = 8'h18;
    localparam logic [7:0] OFS_TIMEBASE   = 8'h1C;
    localparam logic [7:0] OFS_DEB_COUNT  = 8'h20;
    localparam logic [7:0] OFS_DEB_GATE   = 8'h24;
    localparam logic [7:0] OFS_STATUS     = 8'h28;
    localparam logic [7:0] OFS_COUNT      = 8'h2C;
    localparam logic [7:0] OFS_SPAN       = 8'h30;
    localparam logic [7:0] OFS_PERIOD_REM = 8'h34;
    localparam logic [7:0] OFS_TB_REM     = 8'h38;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTL_MODE_LSB   = 0;
    localparam int CTL_END_LSB    = 4;
    localparam int CTL_AUTOSTART  = 8;
    localparam int CTL_TRIGGER    = 9;
    localparam int CTL_REARM      = 10;
    localparam int CTL_LEVEL_EN   = 11;
    localparam int CTL_CONTINUOUS = 12;
    localparam int CTL_INV_COUNT  = 13;
    localparam int CTL_INV_GATE   = 14;
    localparam int CTL_INV_PULSE  = 15;
    localparam int CTL_WIDTH      = 16;
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 16'h0000;

    // command register bits, write-only pulses
    localparam int CMD_START = 0;
    localparam int CMD_CLEAR = 1;
    localparam int CMD_STOP  = 2;

    // status register bits
    localparam int STS_RUNNING = 0;
    localparam int STS_ARMED   = 1;
    localparam int STS_DONE    = 2;
    localparam int STS_PULSE   = 3;
    localparam int STS_COUNT_I = 4;
    localparam int STS_GATE_I  = 5;

    typedef enum logic [2:0] {
        MCT_MODE_TIMER   = 3'b000,
        MCT_MODE_EVENT   = 3'b001,
        MCT_MODE_TPPM    = 3'b010,
        MCT_MODE_HALF    = 3'b011,
        MCT_MODE_NPERIOD = 3'b100,
        MCT_MODE_QUAD    = 3'b101
    } mct_mode_t;

    typedef enum logic [2:0] {
        MCT_END_CMP_LOW  = 3'b000,
        MCT_END_CMP_HIGH = 3'b001,
        MCT_END_ALL_ONES = 3'b010,
        MCT_END_PERIODS  = 3'b011,
        MCT_END_TIMEBASE = 3'b100,
        MCT_END_GATE_FALL = 3'b101
    } mct_end_t;

    typedef enum logic [1:0] {
        MCT_ST_IDLE  = 2'b00,
        MCT_ST_ARMED = 2'b01,
        MCT_ST_RUN   = 2'b10,
        MCT_ST_DONE  = 2'b11
    } mct_state_t;

endpackage

/* hdl/mct_counter_timer.sv */
// multimode counter/timer channel with APB register access
//
// Decided for this implementation: the APB register port and the register addresses.
module mct_counter_timer
    import mct_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int DEB_W = 16
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external signals
    input  wire logic        count_input,
    input  wire logic        gate_input,
    output logic             pulse_output
);

    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_MAX  = '1;
    localparam logic [DEB_W-1:0] DEB_ONE  = DEB_W'(1);

    // ****************************************
    // registers
    // ****************************************
    logic [CTL_WIDTH-1:0] control;
    logic [CNT_W-1:0]     initial_load_value;
    logic [CNT_W-1:0]     low_phase_compare;
    logic [CNT_W-1:0]     high_phase_compare;
    logic [CNT_W-1:0]     clock_divider_value;
    logic [CNT_W-1:0]     period_count_value;
    logic [CNT_W-1:0]     timebase_value;
    logic [DEB_W-1:0]     deb_limit [2];

    logic [CNT_W-1:0]     count;
    logic [CNT_W-1:0]     span;
    logic [CNT_W-1:0]     span_run;
    logic [CNT_W-1:0]     periods_left;
    logic [CNT_W-1:0]     timebase_left;
    logic [CNT_W-1:0]     div_cnt;
    logic                 seen_edge;
    mct_state_t           state;

    logic                 wr_en;
    logic                 cmd_start;
    logic                 cmd_clear;
    logic                 cmd_stop;
    logic                 mapped;

    mct_mode_t            mode;
    mct_end_t             end_mode;

    assign mode     = mct_mode_t'(control[CTL_MODE_LSB +: 3]);
    assign end_mode = mct_end_t'(control[CTL_END_LSB +: 3]);

    function automatic logic is_mapped(input logic [7:0] a);
        unique case (a)
            OFS_CONTROL, OFS_COMMAND, OFS_LOAD, OFS_CMP_LOW, OFS_CMP_HIGH,
            OFS_DIVIDER, OFS_PERIODS, OFS_TIMEBASE, OFS_DEB_COUNT,
            OFS_DEB_GATE, OFS_STATUS, OFS_COUNT, OFS_SPAN, OFS_PERIOD_REM,
            OFS_TB_REM: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // ****************************************
    // apb slave
    // ****************************************
    // read data is captured in the setup cycle so prdata comes from a flop;
    // every access therefore completes in the first access cycle
    assign mapped  = is_mapped(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en   = psel & penable & pwrite & mapped;

    assign cmd_start = wr_en && (paddr == OFS_COMMAND) && pwdata[CMD_START];
    assign cmd_clear = wr_en && (paddr == OFS_COMMAND) && pwdata[CMD_CLEAR];
    assign cmd_stop  = wr_en && (paddr == OFS_COMMAND) && pwdata[CMD_STOP];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            control             <= CTL_RESET;
            initial_load_value  <= '0;
            low_phase_compare   <= '0;
            high_phase_compare  <= '0;
            clock_divider_value <= '0;
            period_count_value  <= '0;
            timebase_value      <= '0;
            deb_limit[0]        <= '0;
            deb_limit[1]        <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CONTROL:   control             <= pwdata[CTL_WIDTH-1:0];
                OFS_LOAD:      initial_load_value  <= pwdata[CNT_W-1:0];
                OFS_CMP_LOW:   low_phase_compare   <= pwdata[CNT_W-1:0];
                OFS_CMP_HIGH:  high_phase_compare  <= pwdata[CNT_W-1:0];
                OFS_DIVIDER:   clock_divider_value <= pwdata[CNT_W-1:0];
                OFS_PERIODS:   period_count_value  <= pwdata[CNT_W-1:0];
                OFS_TIMEBASE:  timebase_value      <= pwdata[CNT_W-1:0];
                OFS_DEB_COUNT: deb_limit[0]        <= pwdata[DEB_W-1:0];
                OFS_DEB_GATE:  deb_limit[1]        <= pwdata[DEB_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // input inversion and debounce
    // ****************************************
    logic [1:0] raw_in;
    logic [1:0] deb_in;
    logic [1:0] deb_prev;

    assign raw_in[0] = count_input ^ control[CTL_INV_COUNT];
    assign raw_in[1] = gate_input ^ control[CTL_INV_GATE];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_deb
            logic [DEB_W-1:0] stable_cnt;
            // a new level is taken only after it held for the limit;
            // any bounce back restarts the wait
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    stable_cnt   <= '0;
                    deb_in[gi]   <= 1'b0;
                    deb_prev[gi] <= 1'b0;
                end else begin
                    deb_prev[gi] <= deb_in[gi];
                    if (raw_in[gi] == deb_in[gi]) begin
                        stable_cnt <= '0;
                    end else if (stable_cnt >= deb_limit[gi]) begin
                        deb_in[gi] <= raw_in[gi];
                        stable_cnt <= '0;
                    end else begin
                        stable_cnt <= stable_cnt + DEB_ONE;
                    end
                end
            end
        end
    endgenerate

    logic cin_rise;
    logic gate_rise;
    logic gate_fall;
    logic cin_level;
    logic gate_level;

    assign cin_level  = deb_in[0];
    assign gate_level = deb_in[1];
    assign cin_rise   = deb_in[0] & ~deb_prev[0];
    assign gate_rise  = deb_in[1] & ~deb_prev[1];
    assign gate_fall  = ~deb_in[1] & deb_prev[1];

    // ****************************************
    // prescaler
    // ****************************************
    logic tick;
    assign tick = (div_cnt >= clock_divider_value);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= '0;
        end else if (state != MCT_ST_RUN || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + CNT_ONE;
        end
    end

    // ****************************************
    // sequencing
    // ****************************************
    logic use_trigger;
    logic enabled;
    logic terminate;
    logic start_req;

    // quadrature decoding uses the gate for direction, never as trigger
    assign use_trigger = control[CTL_TRIGGER] && (mode != MCT_MODE_QUAD);
    assign enabled     = use_trigger || !control[CTL_LEVEL_EN] || gate_level;
    assign start_req   = cmd_start || control[CTL_AUTOSTART];

    always_comb begin
        unique case (end_mode)
            MCT_END_CMP_LOW:   terminate = (count == low_phase_compare);
            MCT_END_CMP_HIGH:  terminate = (count == high_phase_compare);
            MCT_END_ALL_ONES:  terminate = (count == CNT_MAX);
            MCT_END_PERIODS:   terminate = seen_edge && (periods_left == CNT_ZERO);
            MCT_END_TIMEBASE:  terminate = (timebase_left == CNT_ZERO);
            MCT_END_GATE_FALL: terminate = gate_fall;
            default:           terminate = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= MCT_ST_IDLE;
        end else if (cmd_stop) begin
            state <= MCT_ST_IDLE;
        end else begin
            unique case (state)
                MCT_ST_IDLE, MCT_ST_DONE: begin
                    if (state == MCT_ST_IDLE ? start_req : cmd_start) begin
                        state <= use_trigger ? MCT_ST_ARMED : MCT_ST_RUN;
                    end
                end
                MCT_ST_ARMED: begin
                    if (gate_rise) begin
                        state <= MCT_ST_RUN;
                    end
                end
                MCT_ST_RUN: begin
                    if (terminate) begin
                        if (control[CTL_CONTINUOUS]) begin
                            state <= MCT_ST_RUN;
                        end else if (control[CTL_REARM]) begin
                            state <= use_trigger ? MCT_ST_ARMED : MCT_ST_DONE;
                        end else begin
                            state <= MCT_ST_DONE;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************
    // count datapath
    // ****************************************
    logic reload;
    logic start_now;

    // a fresh run starts whenever the channel leaves idle/done or restarts
    assign start_now = ((state == MCT_ST_IDLE) && start_req && !cmd_stop)
                    || ((state == MCT_ST_DONE) && cmd_start && !cmd_stop);
    assign reload    = start_now || cmd_clear
                    || ((state == MCT_ST_RUN) && terminate
                        && control[CTL_CONTINUOUS]);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (reload) begin
            count <= initial_load_value;
        end else if ((state == MCT_ST_RUN) && terminate && control[CTL_REARM]) begin
            count <= initial_load_value;
        end else if ((state == MCT_ST_RUN) && enabled && !terminate) begin
            // the end value is kept unless CTL_CONTINUOUS or CTL_REARM reloads it: no step on the terminating edge
            unique case (mode)
                MCT_MODE_TIMER: begin
                    if (tick) count <= count + CNT_ONE;
                end
                MCT_MODE_EVENT, MCT_MODE_TPPM: begin
                    if (cin_rise) count <= count + CNT_ONE;
                end
                MCT_MODE_HALF: begin
                    if (cin_level) count <= count + CNT_ONE;
                end
                MCT_MODE_NPERIOD: begin
                    if (seen_edge) count <= count + CNT_ONE;
                end
                MCT_MODE_QUAD: begin
                    if (cin_rise) begin
                        count <= gate_level ? count + CNT_ONE : count - CNT_ONE;
                    end
                end
                default: ;
            endcase
        end
    end

    // periods and timebase counters, plus first-to-last edge span
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            periods_left  <= '0;
            timebase_left <= '0;
            seen_edge     <= 1'b0;
            span_run      <= '0;
            span          <= '0;
        end else if (reload || state != MCT_ST_RUN) begin
            // n edges of input span n-1 edge-to-edge intervals
            periods_left  <= period_count_value - CNT_ONE;
            timebase_left <= timebase_value;
            if (reload) begin
                seen_edge <= 1'b0;
                span_run  <= '0;
                span      <= '0;
            end
        end else if (enabled) begin
            if (tick && timebase_left != CNT_ZERO) begin
                timebase_left <= timebase_left - CNT_ONE;
            end
            if (seen_edge) begin
                span_run <= span_run + CNT_ONE;
            end
            if (cin_rise) begin
                seen_edge <= 1'b1;
                if (seen_edge) begin
                    span <= span_run + CNT_ONE;
                    if (periods_left != CNT_ZERO) begin
                        periods_left <= periods_left - CNT_ONE;
                    end
                end
            end
        end
    end

    // ****************************************
    // pulse output
    // ****************************************
    // framed only while running so the idle channel rests at the CTL_INV_PULSE level
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pulse_output <= 1'b0;
        end else begin
            pulse_output <= control[CTL_INV_PULSE]
                ^ ((state == MCT_ST_RUN)
                   && (count >= low_phase_compare)
                   && (count < high_phase_compare));
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    logic [31:0] rd_value;

    always_comb begin
        rd_value = '0;
        unique case (paddr)
            OFS_CONTROL:    rd_value[CTL_WIDTH-1:0] = control;
            OFS_LOAD:       rd_value[CNT_W-1:0] = initial_load_value;
            OFS_CMP_LOW:    rd_value[CNT_W-1:0] = low_phase_compare;
            OFS_CMP_HIGH:   rd_value[CNT_W-1:0] = high_phase_compare;
            OFS_DIVIDER:    rd_value[CNT_W-1:0] = clock_divider_value;
            OFS_PERIODS:    rd_value[CNT_W-1:0] = period_count_value;
            OFS_TIMEBASE:   rd_value[CNT_W-1:0] = timebase_value;
            OFS_DEB_COUNT:  rd_value[DEB_W-1:0] = deb_limit[0];
            OFS_DEB_GATE:   rd_value[DEB_W-1:0] = deb_limit[1];
            OFS_STATUS: begin
                rd_value[STS_RUNNING] = (state == MCT_ST_RUN);
                rd_value[STS_ARMED]   = (state == MCT_ST_ARMED);
                rd_value[STS_DONE]    = (state == MCT_ST_DONE);
                rd_value[STS_PULSE]   = pulse_output;
                rd_value[STS_COUNT_I] = cin_level;
                rd_value[STS_GATE_I]  = gate_level;
            end
            OFS_COUNT:      rd_value[CNT_W-1:0] = count;
            OFS_SPAN:       rd_value[CNT_W-1:0] = span;
            OFS_PERIOD_REM: rd_value[CNT_W-1:0] = periods_left;
            OFS_TB_REM:     rd_value[CNT_W-1:0] = timebase_left;
            default: ;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_value;
        end
    end

endmodule

/* bench/mct_counter_timer_checker.sv */
// checker: bus and pulse output relations of the counter/timer channel
module mct_counter_timer_checker
    import mct_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // external
    input wire logic        pulse_output
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic cfg_seen;
    logic bad_addr;
    logic rd_acc;

    assign bad_addr = (paddr > OFS_TB_REM) || (paddr[1:0] != 2'b00);
    assign rd_acc   = psel && penable && !pwrite;

    // nothing may move the pin until software has written something
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_seen <= 1'b0;
        end else if (psel && penable && pwrite) begin
            cfg_seen <= 1'b1;
        end
    end

    a_ready_high: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    a_err_setup: assert property (psel && !penable ##1 psel && penable && bad_addr |-> pslverr)
        else $error("no error on unmapped access");
    a_err_quiet: assert property (psel && !penable |-> !pslverr)
        else $error("error in setup cycle");
    a_err_mapped: assert property (psel && penable && !bad_addr |-> !pslverr)
        else $error("error on mapped access");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    a_rdata_unmapped: assert property (rd_acc && bad_addr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_idle_low: assert property (!cfg_seen |-> !pulse_output)
        else $error("pulse output active before setup");
    a_reset_reads: assert property (!cfg_seen && rd_acc && paddr != OFS_STATUS |-> prdata == 32'h0)
        else $error("register not cleared by reset");

    c_pulse_rise: cover property ($rose(pulse_output));
    c_pulse_fall: cover property ($fell(pulse_output));
    c_unmapped: cover property (psel && penable && pslverr);
endmodule

bind mct_counter_timer mct_counter_timer_checker u_checker (.core_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .pulse_output);

/* bench/mct_ext_model.sv */
// far-side model: count and gate sources, pulse output monitor
module mct_ext_model (
    // clock
    input  wire logic core_clk,
    // far-side pins
    output logic      count_input,
    output logic      gate_input,
    input  wire logic pulse_output,
    // observation
    output int        high_cycles
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        count_input = 1'b0;
        gate_input  = 1'b0;
        high_cycles = 0;
    end

    always @(posedge core_clk) begin
        if (pulse_output === 1'b1) begin
            high_cycles <= high_cycles + 1;
        end
    end

    // pulses shorter than the debounce span must vanish
    task automatic pulses(input int n, input int hi, input int lo);
        repeat (n) begin
            count_input <= 1'b1;
            repeat (hi) @(posedge core_clk);
            count_input <= 1'b0;
            repeat (lo) @(posedge core_clk);
        end
    endtask

    task automatic set_gate(input logic v);
        gate_input <= v;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

/* bench/mct_counter_timer_tb_top.sv */
// testbench: register bus, timer, event, quadrature and trigger scenarios
module mct_counter_timer_tb_top
    import mct_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        count_input;
    logic        gate_input;
    logic        pulse_output;
    logic        last_err;
    int          high_cycles;
    int          miscompares = 0;
    int          cmp_count = 0;

    mct_counter_timer u_mct_counter_timer (.core_clk, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .count_input, .gate_input,
        .pulse_output);
    mct_ext_model u_mct_ext_model (.core_clk, .count_input, .gate_input, .pulse_output,
        .high_cycles);

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task automatic wait_done();
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h0;
        while (q[STS_DONE] !== 1'b1 && n < 200) begin
            apb(1'b0, OFS_STATUS, 32'h0, q);
            n++;
        end
        chk({31'h0, q[STS_DONE]}, 32'h1);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] q;
        for (int a = 0; a <= 'h24; a += 4) begin
            if (a != 4) rd_chk(8'(a), 32'h0);
        end
        wr(OFS_COUNT, 32'h5);
        rd_chk(OFS_COUNT, 32'h0);
        apb(1'b0, 8'h3C, 32'h0, q);
        chk({31'h0, last_err}, 32'h1);
        chk(q, 32'h0);
    endtask

    task automatic t_timer(input logic [31:0] ld, input logic [31:0] div,
                           input logic [2:0] endm, input logic [31:0] exp_cnt, input int exp_hi);
        int h0;
        wr(OFS_LOAD, ld);
        wr(OFS_CMP_LOW, 32'h2);
        wr(OFS_CMP_HIGH, 32'h5);
        wr(OFS_DIVIDER, div);
        wr(OFS_CONTROL, {25'h0, endm, 1'b0, MCT_MODE_TIMER});
        h0 = high_cycles;
        wr(OFS_COMMAND, 32'h1);
        wait_done();
        rd_chk(OFS_COUNT, exp_cnt);
        if (exp_hi >= 0) chk(32'(high_cycles - h0), 32'(exp_hi));
    endtask

    task automatic t_event();
        wr(OFS_DIVIDER, 32'h0);
        wr(OFS_LOAD, 32'h0);
        wr(OFS_DEB_COUNT, 32'h3);
        wr(OFS_CONTROL, {25'h0, MCT_END_ALL_ONES, 1'b0, MCT_MODE_EVENT});
        wr(OFS_COMMAND, 32'h1);
        u_mct_ext_model.pulses(4, 2, 6);
        rd_chk(OFS_COUNT, 32'h0);
        u_mct_ext_model.pulses(3, 8, 8);
        rd_chk(OFS_COUNT, 32'h3);
        wr(OFS_COMMAND, 32'h4);
    endtask

    task automatic t_quad();
        wr(OFS_DEB_COUNT, 32'h0);
        wr(OFS_LOAD, 32'hA);
        wr(OFS_COMMAND, 32'h2);
        rd_chk(OFS_COUNT, 32'hA);
        wr(OFS_CONTROL, {25'h0, MCT_END_ALL_ONES, 1'b0, MCT_MODE_QUAD});
        wr(OFS_COMMAND, 32'h1);
        u_mct_ext_model.set_gate(1'b1);
        u_mct_ext_model.pulses(3, 4, 4);
        u_mct_ext_model.set_gate(1'b0);
        u_mct_ext_model.pulses(1, 4, 4);
        rd_chk(OFS_COUNT, 32'hC);
        wr(OFS_COMMAND, 32'h4);
    endtask

    // gate rise triggers the armed start and its fall ends the run
    task automatic t_trigger();
        logic [31:0] q;
        wr(OFS_LOAD, 32'h0);
        wr(OFS_CONTROL, 32'h00000250);
        wr(OFS_COMMAND, 32'h1);
        repeat (10) @(posedge core_clk);
        rd_chk(OFS_COUNT, 32'h0);
        u_mct_ext_model.set_gate(1'b1);
        repeat (20) @(posedge core_clk);
        u_mct_ext_model.set_gate(1'b0);
        apb(1'b0, OFS_STATUS, 32'h0, q);
        chk(q & 32'h5, 32'h4);
        // counted from the third edge after the gate rises until its fall is seen
        rd_chk(OFS_COUNT, 32'h17);
        rd_chk(OFS_COUNT, 32'h17);
    endtask

    task automatic t_modes();
        logic [31:0] q;
        wr(OFS_CONTROL, {25'h0, MCT_END_ALL_ONES, 1'b0, MCT_MODE_HALF});
        wr(OFS_COMMAND, 32'h1);
        u_mct_ext_model.pulses(2, 5, 3);
        rd_chk(OFS_COUNT, 32'hA);
        wr(OFS_COMMAND, 32'h4);
        wr(OFS_PERIODS, 32'h3);
        wr(OFS_CONTROL, {25'h0, MCT_END_PERIODS, 1'b0, MCT_MODE_NPERIOD});
        wr(OFS_COMMAND, 32'h1);
        u_mct_ext_model.pulses(3, 4, 4);
        wait_done();
        rd_chk(OFS_COUNT, 32'h10);
        rd_chk(OFS_SPAN, 32'h10);
        wr(OFS_CONTROL, 32'h00001010);
        wr(OFS_COMMAND, 32'h1);
        repeat (20) @(posedge core_clk);
        apb(1'b0, OFS_STATUS, 32'h0, q);
        chk(q & 32'h5, 32'h1);
        wr(OFS_COMMAND, 32'h4);
        wr(OFS_CONTROL, 32'h00000410);
        wr(OFS_COMMAND, 32'h1);
        wait_done();
        rd_chk(OFS_COUNT, 32'h0);
        wr(OFS_CONTROL, 32'h00000820);
        wr(OFS_COMMAND, 32'h1);
        repeat (10) @(posedge core_clk);
        rd_chk(OFS_COUNT, 32'h0);
        wr(OFS_COMMAND, 32'h4);
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_timer(32'h0, 32'h0, MCT_END_CMP_HIGH, 32'h5, 3);
        t_timer(32'h0, 32'h1, MCT_END_CMP_HIGH, 32'h5, 6);
        t_timer(32'h0, 32'h0, MCT_END_CMP_LOW, 32'h2, -1);
        t_timer(32'hFFFFFFFC, 32'h0, MCT_END_ALL_ONES, 32'hFFFFFFFF, 0);
        t_event();
        t_quad();
        t_trigger();
        t_modes();
        summarize();
    end

    // the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        summarize();
    end
endmodule
